// >>> logic/fault_resp_pkg.sv
package fault_resp_pkg;
  localparam int          NUM_FLAGS      = 8;
  localparam int          FLAG_EXT       = 7;
  localparam int          CLK_HZ         = 40_000_000;
  // register offsets (word index on the plain port)
  localparam logic [3:0]  OFS_CFG0       = 4'h0;
  localparam logic [3:0]  OFS_CFG1       = 4'h1;
  localparam logic [3:0]  OFS_CFG2       = 4'h2;
  localparam logic [3:0]  OFS_CFG3       = 4'h3;
  localparam logic [3:0]  OFS_DELAY_EXT  = 4'h6;
  localparam logic [3:0]  OFS_FLAG_STAT  = 4'h8;
  localparam logic [3:0]  OFS_IRQ_STAT   = 4'h9;
  localparam logic [3:0]  OFS_IRQ_EN     = 4'ha;
  localparam logic [3:0]  OFS_IRQ_CLR    = 4'hb;
  localparam logic [3:0]  OFS_CHAN_STAT  = 4'hc;
  // field positions
  localparam int          ACT_LSB        = 2;
  localparam int          CLR_LSB        = 0;
  localparam int          DLY_LSB        = 6;
  localparam int          OV_IGNORE_BIT  = 5;
  localparam int          OV_DEB_BIT     = 4;
  // reset values
  localparam logic [7:0]  CFG_RST        = 8'h00;
  localparam logic [7:0]  DELAY_EXT_RST  = 8'h00;
  // action and after-clear codes
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_CHAN_A     = 2'h1;
  localparam logic [1:0]  ACT_CHAN_B     = 2'h2;
  localparam logic [1:0]  ACT_ALL        = 2'h3;
  localparam logic [1:0]  CLR_DELAYED    = 2'h0;
  localparam logic [1:0]  CLR_IMMEDIATE  = 2'h1;
  // times
  localparam int          DLY_MS_0       = 250;
  localparam int          DLY_MS_1       = 500;
  localparam int          DLY_MS_2       = 1000;
  localparam int          DLY_MS_3       = 2000;
  localparam int          OV_DEB_LONG_US = 500;
  localparam int          OV_DEB_SHORT_US = 2;
  localparam int          TICK_US        = 1000;
  localparam int          TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          OV_DEB_LONG_CYC  = CLK_HZ / 1_000_000 * OV_DEB_LONG_US;
  localparam int          OV_DEB_SHORT_CYC = CLK_HZ / 1_000_000 * OV_DEB_SHORT_US;
endpackage

// >>> logic/flag_restart.sv
`timescale 1ns/1ps
module flag_restart
  import fault_resp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        flag,
  input  wire logic [1:0]  clr_mode,
  input  wire logic [15:0] delay_ticks,
  input  wire logic        tick,
  input  wire logic        power_on_request,
  output logic             hold,
  output logic             want_soft_start
);
  typedef enum logic [1:0] {S_IDLE, S_ACTIVE, S_DELAY, S_WAIT_PON} state_e_t;
  typedef struct packed {
    state_e_t    st;
    logic [15:0] cnt;
    logic        ss;
  } st_t;
  st_t q, d;

  always_comb begin
    d = q;
    d.ss = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (flag) begin
          d.st = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        if (!flag) begin
          d.cnt = 16'h0000;
          if (clr_mode == CLR_DELAYED) begin
            d.st = S_DELAY;
          end else if (clr_mode == CLR_IMMEDIATE) begin
            d.st = S_IDLE;
          end else begin
            d.st = S_WAIT_PON;
          end
        end
      end
      S_DELAY: begin
        if (flag) begin
          d.st = S_ACTIVE;
        end else if (q.cnt >= delay_ticks) begin
          d.st = S_IDLE;
          d.ss = 1'b1;
        end else if (tick) begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      S_WAIT_PON: begin
        if (flag) begin
          d.st = S_ACTIVE;
        end else if (power_on_request) begin
          d.st = S_IDLE;
          d.ss = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '{st: S_IDLE, cnt: 16'h0000, ss: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign hold            = (q.st != S_IDLE);
  assign want_soft_start = q.ss;
endmodule

// >>> logic/fault_response_ctrl.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - action 00 none, 01 stop channel a, 10 stop channel b, 11 stop all
// - after-clear 00: wait reenable delay, then restart with soft start
// - after-clear 01: restart at once, no soft start
// - after-clear 10/11: stay off until power-on request
// - global delay code 00 250ms, 01 500ms, 10 1s, 11 2s
// - ignore bit holds supply overvoltage flag cleared; else condition sets it
// - enabled supply overvoltage flag clearing after set restarts whole part
// - debounce bit: 0 needs 500us, 1 needs 2us of condition
// - external fault input has own action field, same encoding
// - external fault input has own after-clear field, same encoding
// - each fault flag and the external input owns one nibble (action and after-clear fields); the supply overvoltage flag owns none
module fault_response_ctrl
  import fault_resp_pkg::*;
#(
  parameter int OV_LONG_CYC  = OV_DEB_LONG_CYC,
  parameter int TICK_CYC     = TICK_CYCLES
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic [3:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output logic      [7:0]           rdata,
  input  wire logic [NUM_FLAGS-2:0] fault_flags,
  input  wire logic                 external_fault_input,
  input  wire logic                 supply_overvoltage_cond,
  input  wire logic                 power_on_request,
  output logic                      chan_a_disable,
  output logic                      chan_b_disable,
  output logic                      chan_c_disable,
  output logic                      soft_start_req,
  output logic                      part_restart,
  output logic                      supply_overvoltage_flag,
  output logic                      irq
);
  typedef struct packed {
    logic [3:0][7:0]          cfg;
    logic [7:0]               dext;
    logic [31:0]              ov_cnt;
    logic                     ov_flag;
    logic [31:0]              pre;
    logic                     tick;
    logic [3:0]               ist;
    logic [3:0]               ien;
    logic [NUM_FLAGS-1:0]     flags_prev;
    logic [7:0]               rdata;
    logic                     dis_a;
    logic                     dis_b;
    logic                     dis_c;
    logic                     ss;
    logic                     restart;
    logic                     irq;
  } st_t;
  st_t q, d;

  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] hold;
  logic [NUM_FLAGS-1:0] ss_req;
  logic [15:0]          delay_ticks;
  logic [NUM_FLAGS-1:0][3:0] nib;

  function automatic logic [3:0] nibble(input logic [3:0][7:0] c, input logic [7:0] e,
                                        input int i);
    if (i == FLAG_EXT) begin
      return e[3:0];
    end
    return i[0] ? c[i/2][7:4] : c[i/2][3:0];
  endfunction

  function automatic logic [15:0] ticks_for(input logic [1:0] code);
    unique case (code)
      2'h0: return 16'(DLY_MS_0);
      2'h1: return 16'(DLY_MS_1);
      2'h2: return 16'(DLY_MS_2);
      2'h3: return 16'(DLY_MS_3);
    endcase
  endfunction

  assign flags       = {external_fault_input, fault_flags};
  assign delay_ticks = ticks_for(q.dext[DLY_LSB +: 2]);

  for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
    // decoded once per flag, shared by restarter and action logic
    assign nib[g] = nibble(q.cfg, q.dext, g);
    flag_restart u_rst (
      .mclk             (mclk),
      .rstn             (rstn),
      .flag             (flags[g]),
      .clr_mode         (nib[g][CLR_LSB +: 2]),
      .delay_ticks      (delay_ticks),
      .tick             (q.tick),
      .power_on_request (power_on_request),
      .hold             (hold[g]),
      .want_soft_start  (ss_req[g])
    );
  end

  always_comb begin
    logic [1:0] act;
    logic       a;
    logic       b;
    logic       c;
    logic [3:0] ev;
    act = 2'h0;
    ev = 4'h0;
    a = 1'b0;
    b = 1'b0;
    c = 1'b0;
    d = q;
    // prescaler: a 1 ms tick keeps the delay counters narrow
    d.tick = 1'b0;
    if (q.pre >= 32'(TICK_CYC - 1)) begin
      d.pre  = 32'h0000_0000;
      d.tick = 1'b1;
    end else begin
      d.pre = q.pre + 32'h0000_0001;
    end
    // supply overvoltage debounce
    if (q.dext[OV_IGNORE_BIT]) begin
      d.ov_flag = 1'b0;
      d.ov_cnt  = 32'h0000_0000;
    end else if (!supply_overvoltage_cond) begin
      d.ov_cnt  = 32'h0000_0000;
      d.ov_flag = 1'b0;
    end else if (q.ov_cnt >= 32'(q.dext[OV_DEB_BIT] ? OV_DEB_SHORT_CYC : OV_LONG_CYC) - 1) begin
      d.ov_flag = 1'b1;
    end else begin
      d.ov_cnt = q.ov_cnt + 32'h0000_0001;
    end
    d.restart = q.ov_flag && !d.ov_flag && !q.dext[OV_IGNORE_BIT];
    // channel disables from held flags
    for (int i = 0; i < NUM_FLAGS; i++) begin
      act = nib[i][ACT_LSB +: 2];
      if (hold[i] || flags[i]) begin
        a = a | (act == ACT_CHAN_A) | (act == ACT_ALL);
        b = b | (act == ACT_CHAN_B) | (act == ACT_ALL);
        c = c | (act == ACT_ALL);
      end
    end
    d.dis_a = a;
    d.dis_b = b;
    d.dis_c = c;
    d.ss    = |ss_req;
    d.flags_prev = flags;
    // events: new flag, soft start, part restart, ov flag set
    ev = {d.ov_flag & ~q.ov_flag, d.restart, d.ss, |(flags & ~q.flags_prev)};
    // register bus
    d.rdata = 8'h00;
    if (wr_stb) begin
      unique case (addr)
        OFS_CFG0, OFS_CFG1, OFS_CFG2, OFS_CFG3: d.cfg[addr[1:0]] = wdata;
        OFS_DELAY_EXT: d.dext = wdata;
        OFS_IRQ_EN:    d.ien  = wdata[3:0];
        OFS_IRQ_CLR:   d.ist  = q.ist & ~wdata[3:0];
        default: ;
      endcase
    end
    d.ist = d.ist | ev; // set wins over clear
    if (rd_stb) begin
      unique case (addr)
        OFS_CFG0, OFS_CFG1, OFS_CFG2, OFS_CFG3: d.rdata = q.cfg[addr[1:0]];
        OFS_DELAY_EXT: d.rdata = q.dext;
        OFS_FLAG_STAT: d.rdata = flags;
        OFS_IRQ_STAT:  d.rdata = {4'h0, q.ist};
        OFS_IRQ_EN:    d.rdata = {4'h0, q.ien};
        OFS_CHAN_STAT: d.rdata = {4'h0, q.ov_flag, q.dis_c, q.dis_b, q.dis_a};
        default:       d.rdata = 8'h00;
      endcase
    end
    d.irq = |(d.ist & d.ien);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q      <= '0;
      q.cfg  <= {4{CFG_RST}};
      q.dext <= DELAY_EXT_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata                   = q.rdata;
  assign chan_a_disable          = q.dis_a;
  assign chan_b_disable          = q.dis_b;
  assign chan_c_disable          = q.dis_c;
  assign soft_start_req          = q.ss;
  assign part_restart            = q.restart;
  assign supply_overvoltage_flag = q.ov_flag;
  assign irq                     = q.irq;
endmodule

// >>> testbench/fault_response_monitor.sv
`timescale 1ns/1ps
module fault_response_monitor
  import fault_resp_pkg::*;
#(
  parameter int OV_LONG_CYC = OV_DEB_LONG_CYC,
  parameter int TICK_CYC    = TICK_CYCLES
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [6:0] fault_flags,
  input wire logic       external_fault_input,
  input wire logic       supply_overvoltage_cond,
  input wire logic       power_on_request,
  input wire logic       chan_a_disable,
  input wire logic       chan_b_disable,
  input wire logic       chan_c_disable,
  input wire logic       part_restart,
  input wire logic       supply_overvoltage_flag
);
  logic [7:0]  cfg_q;
  logic [7:0]  ext_q;
  logic [15:0] ovc_q;
  int          need;
  assign need = ext_q[OV_DEB_BIT] ? OV_DEB_SHORT_CYC : OV_LONG_CYC;
  // shadows of the OFS_CFG0 and OFS_DELAY_EXT config registers, seen only through writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
      ext_q <= DELAY_EXT_RST;
      ovc_q <= 16'h0000;
    end else begin
      if (wr_stb && addr == OFS_CFG0) cfg_q <= wdata;
      if (wr_stb && addr == OFS_DELAY_EXT) ext_q <= wdata;
      ovc_q <= !supply_overvoltage_cond ? 16'h0000 : ovc_q + 16'(ovc_q != 16'hffff);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_flag0_action: assert property ($rose(fault_flags[0]) |-> ##1
    (chan_a_disable || !cfg_q[2]) && (chan_b_disable || !cfg_q[3]))
    else $error("flag action not applied");
  a_ext_action: assert property ($rose(external_fault_input) |-> ##1
    (chan_a_disable || !ext_q[2]) && (chan_c_disable || ext_q[3:2] != 2'h3))
    else $error("external action not applied");
  a_imm_release: assert property ($fell(external_fault_input) && ext_q[3:0] == 4'h5
    && fault_flags == 7'h00 |-> ##2 !chan_a_disable)
    else $error("immediate restart late");
  a_pwr_hold: assert property ($fell(external_fault_input) && ext_q[3:1] == 3'h3
    && !power_on_request |-> chan_a_disable [*8])
    else $error("restart without power on request");
  a_ov_ignored: assert property (ext_q[OV_IGNORE_BIT] |-> ##1 !supply_overvoltage_flag)
    else $error("ignored flag set");
  a_ov_restart: assert property ($fell(supply_overvoltage_flag) && !ext_q[OV_IGNORE_BIT]
    |-> ##[0:1] part_restart)
    else $error("no part restart");
  a_ov_debounce: assert property ($rose(supply_overvoltage_flag) |->
    int'(ovc_q) + 2 >= need && int'(ovc_q) <= need + 2)
    else $error("debounce length wrong");
endmodule
bind fault_response_ctrl fault_response_monitor #(
  .OV_LONG_CYC(OV_LONG_CYC), .TICK_CYC(TICK_CYC)) fault_response_monitor_i (
  .mclk                    (mclk),
  .rstn                    (rstn),
  .addr                    (addr),
  .wdata                   (wdata),
  .wr_stb                  (wr_stb),
  .rd_stb                  (rd_stb),
  .rdata                   (rdata),
  .fault_flags             (fault_flags),
  .external_fault_input    (external_fault_input),
  .supply_overvoltage_cond (supply_overvoltage_cond),
  .power_on_request        (power_on_request),
  .chan_a_disable          (chan_a_disable),
  .chan_b_disable          (chan_b_disable),
  .chan_c_disable          (chan_c_disable),
  .part_restart            (part_restart),
  .supply_overvoltage_flag (supply_overvoltage_flag)
);

// >>> testbench/fault_response_ctrl_tb.sv
`timescale 1ns/1ps
module fault_response_ctrl_tb
  import fault_resp_pkg::*;
;
  localparam int TICK = 4;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic [6:0] fault_flags = 7'h00;
  logic       external_fault_input = 1'b0;
  logic       supply_overvoltage_cond = 1'b0;
  logic       power_on_request = 1'b0;
  logic [7:0] rdata;
  logic       chan_a_disable, chan_b_disable, chan_c_disable, soft_start_req;
  logic       part_restart, supply_overvoltage_flag, irq;
  logic [1:0] seen = 2'h0;
  int         fail_count = 0;
  int         compares = 0;
  int         cycles = 0;
  fault_response_ctrl #(.OV_LONG_CYC(10), .TICK_CYC(TICK)) fault_response_ctrl_i (
    .mclk                    (mclk),
    .rstn                    (rstn),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr_stb                  (wr_stb),
    .rd_stb                  (rd_stb),
    .rdata                   (rdata),
    .fault_flags             (fault_flags),
    .external_fault_input    (external_fault_input),
    .supply_overvoltage_cond (supply_overvoltage_cond),
    .power_on_request        (power_on_request),
    .chan_a_disable          (chan_a_disable),
    .chan_b_disable          (chan_b_disable),
    .chan_c_disable          (chan_c_disable),
    .soft_start_req          (soft_start_req),
    .part_restart            (part_restart),
    .supply_overvoltage_flag (supply_overvoltage_flag),
    .irq                     (irq)
  );
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (soft_start_req === 1'b1) seen[0] <= 1'b1;
    if (part_restart === 1'b1) seen[1] <= 1'b1;
    if (cycles == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask
  task automatic ext(input logic v);
    @(posedge mclk);
    external_fault_input <= v;
  endtask
  function automatic logic [2:0] dis();
    return {chan_c_disable, chan_b_disable, chan_a_disable};
  endfunction
  // source 0 and 1 share one register, one nibble each
  task automatic trip(input int s, input logic [1:0] c);
    logic [7:0] v;
    v = {4'h0, c, 2'h1};
    wr(s == 2 ? OFS_DELAY_EXT : OFS_CFG0, s == 1 ? v << 4 : v);
    @(posedge mclk);
    fault_flags <= 7'(s < 2 ? 1 << s : 0);
    external_fault_input <= (s == 2);
    cyc(2);
    chk("action", dis(), c == 2'h3 ? 3'h7 : {1'b0, c});
    @(posedge mclk);
    fault_flags <= 7'h00;
    external_fault_input <= 1'b0;
    cyc(3);
    chk("release", dis(), 3'h0);
  endtask
  // tick phase is free running, so allow a few cycles either way
  task automatic delayed(input logic [1:0] c, input logic ab);
    int n;
    int t;
    n = 0;
    t = TICK * (c == 0 ? DLY_MS_0 : c == 1 ? DLY_MS_1 : c == 2 ? DLY_MS_2 : DLY_MS_3);
    wr(OFS_DELAY_EXT, {c, 6'h04});
    ext(1'b1);
    ext(1'b0);
    if (ab) begin
      cyc(t / 2);
      ext(1'b1);
      ext(1'b0);
    end
    // step off the edge that launches the disable, else it still reads low
    #1;
    seen = 2'h0;
    while (chan_a_disable === 1'b1 && n < 9000) begin
      cyc(1);
      n++;
    end
    chk("delay", 16'(n + TICK >= t && n <= t + 3 * TICK), 16'h1);
    // the pulse is caught by the edge sampler one edge after release
    cyc(1);
    chk("soft start", seen[0], 1'b1);
  endtask
  initial begin
    int k;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(OFS_CFG0, CFG_RST);
    rd(OFS_DELAY_EXT, DELAY_EXT_RST);
    rd(4'hf, 8'h00);
    wr(OFS_CFG1, 8'ha5);
    rd(OFS_CFG1, 8'ha5);
    $display("registers done");
    for (k = 0; k < 12; k++) trip(k / 4, 2'(k % 4));
    $display("actions done");
    for (k = 0; k < 4; k++) delayed(2'(k), k == 0);
    $display("delays done");
    for (k = 6; k < 8; k++) begin
      wr(OFS_DELAY_EXT, 8'(k));
      wr(OFS_CFG0, 8'h05);
      ext(1'b1);
      fault_flags <= 7'h01;
      cyc(2);
      @(posedge mclk) fault_flags <= 7'h00;
      ext(1'b0);
      cyc(20);
      chk("hold", chan_a_disable, 1'b1);
      rd(OFS_CHAN_STAT, 8'h01);
      @(posedge mclk) power_on_request <= 1'b1;
      cyc(3);
      chk("power on", chan_a_disable, 1'b0);
      @(posedge mclk) power_on_request <= 1'b0;
    end
    $display("power on done");
    wr(OFS_DELAY_EXT, 8'h20);
    @(posedge mclk) supply_overvoltage_cond <= 1'b1;
    cyc(200);
    chk("ignore", supply_overvoltage_flag, 1'b0);
    @(posedge mclk) supply_overvoltage_cond <= 1'b0;
    for (k = 0; k < 2; k++) begin
      wr(OFS_DELAY_EXT, k ? 8'h00 : 8'h10);
      @(posedge mclk) supply_overvoltage_cond <= 1'b1;
      seen = 2'h0;
      cyc(k ? 6 : 76);
      chk("debounce", supply_overvoltage_flag, 1'b0);
      cyc(8);
      chk("ov flag", supply_overvoltage_flag, 1'b1);
      @(posedge mclk) supply_overvoltage_cond <= 1'b0;
      cyc(3);
      chk("restart", {seen[1], supply_overvoltage_flag}, 2'h2);
    end
    $display("overvoltage done");
    wr(OFS_IRQ_EN, 8'h0f);
    cyc(2);
    chk("irq", irq, 1'b1);
    wr(OFS_IRQ_CLR, 8'h0f);
    wr(OFS_IRQ_EN, 8'h00);
    rd(OFS_IRQ_STAT, 8'h00);
    @(posedge mclk) fault_flags <= 7'h01;
    cyc(2);
    rd(OFS_FLAG_STAT, 8'h01);
    @(posedge mclk) fault_flags <= 7'h00;
    rd(OFS_IRQ_STAT, 8'h01);
    chk("masked", irq, 1'b0);
    wr(OFS_IRQ_EN, 8'h01);
    cyc(2);
    chk("irq", irq, 1'b1);
    $display("interrupts done");
    tally_and_finish();
  end
endmodule
